// >>> bench/slrs_host.sv
`timescale 1ns/1ps
// spi host model, mode 0, serial clock idle low outside frames
module slrs_host (
    input wire logic clk_sys,
    input wire logic so_out,
    input wire logic so_oe,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic rx_stb,
    output logic [7:0] rx_byte
);
    // idle pins at time zero
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        rx_stb = 1'b0;
        rx_byte = 8'h00;
    end
    // wait n falling clock edges
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wt
    task automatic xfer(input logic [7:0] tx, input int nb, input bit rd);
        for (int i = 7; i > 7 - nb; i--) begin
            si = tx[i];
            wt(4);
            sck = 1'b1;
            wt(4);
            // undriven output reads as unknown
            rx_byte[i] = so_oe ? so_out : 1'bx;
            sck = 1'b0;
        end
        if (rd) begin
            rx_stb = 1'b1;
            wt(1);
            rx_stb = 1'b0;
        end
    endtask : xfer
    // select with settle time for synchronisers
    task automatic open_frame();
        wt(3);
        cs_n = 1'b0;
        wt(4);
    endtask : open_frame
    // release; data line no longer holds its value
    task automatic close_frame();
        wt(4);
        cs_n = 1'b1;
        si = ~si;
        wt(10);
    endtask : close_frame
endmodule : slrs_host

// >>> bench/slrs_top_tb_top.sv
`timescale 1ns/1ps
module slrs_top_tb_top;
    import slrs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cs_n, sck, si, so_out, so_oe, rx_stb, wel_clear, protection_lock_bit;
    logic [7:0] rx_byte, device_status_word;
    logic wp_n = 1'b1;
    logic program_error_flag = 1'b0;
    logic write_enable_latch = 1'b0;
    logic operation_in_progress = 1'b0;
    logic sect_cmd_valid = 1'b0;
    logic sect_cmd_protect = 1'b0;
    logic [3:0] sect_cmd_index = 4'h0;
    logic [15:0] sect_prot, exp_prot;
    logic exp_lock;
    logic [7:0] expq[$];
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int wel_pulses = 0;
    int exp_wel = 0;
    int seed = 8630;
    always #12.5 clk_sys = ~clk_sys;
    slrs_top #(.NUM_SECT(16), .SECT_LSB(17)) slrs_top_inst (.clk_sys, .rst, .cs_n, .sck, .si,
        .wp_n, .so_out, .so_oe, .program_error_flag, .write_enable_latch,
        .operation_in_progress, .sect_cmd_valid, .sect_cmd_protect, .sect_cmd_index,
        .wel_clear, .protection_lock_bit, .sect_prot, .device_status_word);
    slrs_host slrs_host_inst (.clk_sys, .so_out, .so_oe, .cs_n, .sck, .si, .rx_stb, .rx_byte);
    // one comparison of any result
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_val
    // one comparison of a readout or status byte
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t byte %h exp %h", $time, got, exp);
        end
    endtask : check_byte
    // verdict and end of run
    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    // monitor: readout bytes, latch-clear pulses, timeout
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (wel_clear === 1'b1) wel_pulses <= wel_pulses + 1;
        if (rx_stb) check_byte(rx_byte, expq.pop_front());
        if (cycles == 40000) begin
            mismatches++;
            complete_run();
        end
    end
    // expected live status word
    function automatic logic [7:0] stat();
        logic [1:0] s;
        s = (exp_prot == 16'h0000) ? SUM_NONE : ((&exp_prot) ? SUM_ALL : SUM_SOME);
        return {exp_lock, 1'b0, program_error_flag, wp_n, s, write_enable_latch,
            operation_in_progress};
    endfunction : stat
    // status read, two repeats with random error and busy flags
    task automatic read_status();
        @(negedge clk_sys);
        program_error_flag = 1'($random(seed));
        operation_in_progress = 1'($random(seed));
        expq.push_back(stat());
        slrs_host_inst.open_frame();
        slrs_host_inst.xfer(OP_READ_STATUS, 8, 0);
        slrs_host_inst.xfer(8'h00, 8, 1);
        // busy flips between bytes; the next byte must carry the new value
        operation_in_progress = ~operation_in_progress;
        expq.push_back(stat());
        slrs_host_inst.xfer(8'h00, 8, 1);
        slrs_host_inst.close_frame();
        check_byte(device_status_word, stat());
    endtask : read_status
    // sector readout at a random address inside sector n
    task automatic read_sect(input logic [3:0] n);
        logic [23:0] a;
        a = {3'h0, n, 17'h00000} | 24'($random(seed) & 32'h1FFFF);
        expq.push_back(exp_prot[n] ? SECT_BYTE_SET : SECT_BYTE_CLR);
        expq.push_back(exp_prot[n] ? SECT_BYTE_SET : SECT_BYTE_CLR);
        slrs_host_inst.open_frame();
        slrs_host_inst.xfer(OP_READ_SECT_PROT, 8, 0);
        slrs_host_inst.xfer(a[23:16], 8, 0);
        slrs_host_inst.xfer(a[15:8], 8, 0);
        slrs_host_inst.xfer(a[7:0], 8, 0);
        slrs_host_inst.xfer(8'h00, 8, 1);
        slrs_host_inst.xfer(8'h00, 8, 1);
        slrs_host_inst.close_frame();
        check_val(16'(so_oe), 16'h0000);
    endtask : read_sect
    // status write; caller sets the expected lock and sectors first
    task automatic write_status(input logic [7:0] d);
        slrs_host_inst.open_frame();
        slrs_host_inst.xfer(OP_WRITE_STATUS, 8, 0);
        slrs_host_inst.xfer(d, 8, 0);
        slrs_host_inst.close_frame();
        exp_wel++;
        check_val(16'(wel_pulses), 16'(exp_wel));
        check_val(16'(protection_lock_bit), 16'(exp_lock));
        check_val(sect_prot, exp_prot);
    endtask : write_status
    // one-cycle sector protect or unprotect request
    task automatic sect_cmd(input logic p, input logic [3:0] n);
        @(negedge clk_sys);
        sect_cmd_valid = 1'b1;
        sect_cmd_protect = p;
        sect_cmd_index = n;
        @(negedge clk_sys);
        sect_cmd_valid = 1'b0;
        @(negedge clk_sys);
        if (!exp_lock) exp_prot[n] = p;
        check_val(sect_prot, exp_prot);
    endtask : sect_cmd
    // main sequence
    initial begin
        exp_lock = 1'b0;
        exp_prot = 16'hFFFF;
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        write_enable_latch = 1'b1;
        read_status();
        read_sect(4'h9);
        exp_prot = 16'h0000;
        write_status(8'h00);
        sect_cmd(1'b1, 4'h5);
        read_sect(4'h5);
        read_sect(4'h4);
        read_status();
        exp_lock = 1'b1;
        exp_prot = 16'hFFFF;
        write_status(8'hBC);
        sect_cmd(1'b0, 4'h5);
        wp_n = 1'b0;
        write_status(8'h00);
        read_status();
        wp_n = 1'b1;
        exp_lock = 1'b0;
        write_status(8'h3C);
        write_enable_latch = 1'b0;
        write_status(8'h80);
        // unknown opcode: no readout and no latch clear
        slrs_host_inst.open_frame();
        slrs_host_inst.xfer(8'hA5, 8, 0);
        slrs_host_inst.xfer(8'h00, 8, 0);
        check_val(16'(so_oe), 16'h0000);
        slrs_host_inst.close_frame();
        check_val(16'(wel_pulses), 16'(exp_wel));
        slrs_host_inst.open_frame();
        slrs_host_inst.xfer(OP_READ_STATUS, 8, 0);
        slrs_host_inst.xfer(8'h00, 3, 0);
        check_val(16'(so_oe), 16'h0001);
        slrs_host_inst.close_frame();
        check_val(16'(so_oe), 16'h0000);
        write_enable_latch = 1'b1;
        exp_lock = 1'b1;
        exp_prot = 16'h0000;
        write_status(8'h80);
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        exp_lock = 1'b0;
        exp_prot = 16'hFFFF;
        check_val(16'(protection_lock_bit), 16'(exp_lock));
        check_val(sect_prot, exp_prot);
        complete_run();
    end
endmodule : slrs_top_tb_top

// >>> hw/slrs_pkg.sv
package slrs_pkg;
    // command opcodes
    localparam logic [7:0] OP_READ_SECT_PROT = 8'h3C;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    // readout byte patterns
    localparam logic [7:0] SECT_BYTE_SET = 8'hFF;
    localparam logic [7:0] SECT_BYTE_CLR = 8'h00;
    // status word bit positions
    localparam int ST_LOCK_BIT = 7;
    localparam int ST_RSVD_BIT = 6;
    localparam int ST_PERR_BIT = 5;
    localparam int ST_PIN_BIT = 4;
    localparam int ST_SUM_HI = 3;
    localparam int ST_SUM_LO = 2;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    // global protect field in a written status byte
    localparam int WR_GLB_HI = 5;
    localparam int WR_GLB_LO = 2;
    localparam logic [3:0] GLB_PROTECT = 4'hF;
    localparam logic [3:0] GLB_UNPROTECT = 4'h0;
    // protection summary codes
    localparam logic [1:0] SUM_NONE = 2'h0;
    localparam logic [1:0] SUM_SOME = 2'h1;
    localparam logic [1:0] SUM_ALL = 2'h3;
    // reset values and reserved bit value
    localparam logic LOCK_RST = 1'b0;
    localparam logic PROT_RST = 1'b1;
    localparam logic RSVD_VAL = 1'b0;
    // bit and address byte counter values
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [1:0] ADDR_LAST = 2'h2;
    // address field width
    localparam int ADDR_W = 24;
    // command decoder states
    typedef enum logic [2:0] {
        SLRS_CMD = 3'b000,
        SLRS_ADDR = 3'b001,
        SLRS_WDATA = 3'b010,
        SLRS_SREAD = 3'b011,
        SLRS_PREAD = 3'b100,
        SLRS_IGNORE = 3'b101
    } slrs_state_t;
endpackage : slrs_pkg

// >>> hw/slrs_top.sv
`timescale 1ns/1ps
module slrs_top #(
    parameter int NUM_SECT = 16,
    parameter int SECT_LSB = 17
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    output logic so_out,
    output logic so_oe,
    input wire logic program_error_flag,
    input wire logic write_enable_latch,
    input wire logic operation_in_progress,
    input wire logic sect_cmd_valid,
    input wire logic sect_cmd_protect,
    input wire logic [$clog2(NUM_SECT)-1:0] sect_cmd_index,
    output logic wel_clear,
    output logic protection_lock_bit,
    output logic [NUM_SECT-1:0] sect_prot,
    output logic [7:0] device_status_word
);
    import slrs_pkg::*;

    localparam int IDX_W = $clog2(NUM_SECT);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [3:0] meta_ff; // first stage, read only by second stage
    logic [3:0] sync_ff; // cs_n, sck, si, wp_n
    logic cs_n_d_ff; // delayed cs for edge detect
    logic sck_d_ff; // delayed sck for edge detect

    // two flip-flop synchroniser for all pins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_ff <= 4'hF;
            sync_ff <= 4'hF;
            cs_n_d_ff <= 1'b1;
            sck_d_ff <= 1'b0;
        end else begin
            meta_ff <= {cs_n, sck, si, wp_n};
            sync_ff <= meta_ff;
            cs_n_d_ff <= sync_ff[3];
            sck_d_ff <= sync_ff[2];
        end
    end

    wire cs_n_s = sync_ff[3];
    wire sck_s = sync_ff[2];
    wire si_s = sync_ff[1];
    wire wp_n_s = sync_ff[0];
    wire cs_act = ~cs_n_s;
    wire cs_end = cs_n_s & ~cs_n_d_ff; // release of chip select
    wire sck_rise = cs_act & sck_s & ~sck_d_ff;
    wire sck_fall = cs_act & ~sck_s & sck_d_ff;

    ////////////////////////////////////////////////////////////////////////
    // protection state and status word
    logic lock_ff; // protection lock bit
    logic [NUM_SECT-1:0] prot_ff; // per-sector protection bits
    logic [1:0] summary; // protection summary field

    assign summary = (&prot_ff) ? SUM_ALL : ((|prot_ff) ? SUM_SOME : SUM_NONE);

    wire hw_lock = ~wp_n_s & lock_ff;

    always_comb begin
        device_status_word = 8'h00;
        device_status_word[ST_LOCK_BIT] = lock_ff;
        device_status_word[ST_RSVD_BIT] = RSVD_VAL;
        device_status_word[ST_PERR_BIT] = program_error_flag;
        device_status_word[ST_PIN_BIT] = wp_n_s;
        device_status_word[ST_SUM_HI:ST_SUM_LO] = summary;
        device_status_word[ST_WEL_BIT] = write_enable_latch;
        device_status_word[ST_BUSY_BIT] = operation_in_progress;
    end

    ////////////////////////////////////////////////////////////////////////
    // command decoder
    slrs_state_t state_ff, nxt_state;
    logic [7:0] sh_ff; // incoming byte shifter
    logic [2:0] bit_ff; // bit within byte
    logic [1:0] abyte_ff; // address byte count
    logic [ADDR_W-1:0] addr_ff; // captured address
    logic [7:0] wdata_ff; // written status byte
    logic wdone_ff; // full data byte received
    logic wcmd_ff; // write status opcode complete

    wire [7:0] byte_in = {sh_ff[6:0], si_s};
    wire byte_done = sck_rise & (bit_ff == BIT_LAST);

    // next state on completed bytes
    always_comb begin
        nxt_state = state_ff;
        if (byte_done) begin
            case (state_ff)
                SLRS_CMD: begin
                    if (byte_in == OP_READ_SECT_PROT) nxt_state = SLRS_ADDR;
                    else if (byte_in == OP_READ_STATUS) nxt_state = SLRS_SREAD;
                    else if (byte_in == OP_WRITE_STATUS) nxt_state = SLRS_WDATA;
                    else nxt_state = SLRS_IGNORE;
                end
                SLRS_ADDR: begin
                    if (abyte_ff == ADDR_LAST) nxt_state = SLRS_PREAD;
                end
                SLRS_WDATA: nxt_state = SLRS_IGNORE;
                default: nxt_state = state_ff;
            endcase
        end
    end

    // shifter, counters and state register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= SLRS_CMD;
            sh_ff <= 8'h00;
            bit_ff <= BIT_FIRST;
            abyte_ff <= 2'h0;
            addr_ff <= '0;
        end else if (cs_n_s) begin
            state_ff <= SLRS_CMD;
            bit_ff <= BIT_FIRST;
            abyte_ff <= 2'h0;
        end else if (sck_rise) begin
            state_ff <= nxt_state;
            sh_ff <= byte_in;
            bit_ff <= bit_ff + 3'h1;
            if (state_ff == SLRS_ADDR) begin
                addr_ff <= {addr_ff[ADDR_W-2:0], si_s};
                if (byte_done) abyte_ff <= abyte_ff + 2'h1;
            end
        end
    end

    // write status capture, flags cleared after release; data byte kept
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wdata_ff <= 8'h00;
            wdone_ff <= 1'b0;
            wcmd_ff <= 1'b0;
        end else if (cs_n_s) begin
            wdone_ff <= 1'b0;
            wcmd_ff <= 1'b0;
        end else if (byte_done) begin
            if (state_ff == SLRS_CMD && byte_in == OP_WRITE_STATUS) wcmd_ff <= 1'b1;
            // extra data bytes are ignored
            if (state_ff == SLRS_WDATA) begin
                wdata_ff <= byte_in;
                wdone_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status write and sector command effects
    wire new_lock = wdata_ff[ST_LOCK_BIT];
    wire [3:0] glb = wdata_ff[WR_GLB_HI:WR_GLB_LO];
    // clearing lock refused while pin low
    wire lock_ok = ~(lock_ff & ~new_lock & ~wp_n_s);
    // commit on release: full byte, latch set, no hardware lock
    wire wr_apply = cs_end & wcmd_ff & wdone_ff & write_enable_latch & lock_ok & ~hw_lock;
    // global change only from prior unlocked state
    wire glb_ok = wr_apply & ~lock_ff;
    wire glb_prot = glb_ok & (glb == GLB_PROTECT);
    wire glb_unprot = glb_ok & (glb == GLB_UNPROTECT);
    wire sect_ok = sect_cmd_valid & ~lock_ff;

    // lock bit register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock_ff <= LOCK_RST;
        end else if (wr_apply) begin
            lock_ff <= new_lock;
        end
    end

    // sector protection bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prot_ff <= {NUM_SECT{PROT_RST}};
        end else if (glb_prot) begin
            prot_ff <= {NUM_SECT{1'b1}};
        end else if (glb_unprot) begin
            prot_ff <= {NUM_SECT{1'b0}};
        end else if (sect_ok) begin
            prot_ff[sect_cmd_index] <= sect_cmd_protect;
        end
    end

    // latch clear pulse whenever a full write opcode ends
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) wel_clear <= 1'b0;
        else wel_clear <= cs_end & wcmd_ff;
    end

    assign protection_lock_bit = lock_ff;
    assign sect_prot = prot_ff;

    ////////////////////////////////////////////////////////////////////////
    // serial output
    logic so_ff; // output data bit
    logic oe_ff; // output enable
    logic [2:0] oidx_ff; // bit index being sent
    logic [7:0] cap_ff; // sampled status byte
    wire [IDX_W-1:0] sel_sect = addr_ff[SECT_LSB +: IDX_W];
    // sector bit gives FFh or 00h
    wire [7:0] sect_byte = prot_ff[sel_sect] ? SECT_BYTE_SET : SECT_BYTE_CLR;
    wire in_read = (state_ff == SLRS_SREAD) | (state_ff == SLRS_PREAD);

    // shift data out on falling clock edges
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            so_ff <= 1'b0;
            oe_ff <= 1'b0;
            oidx_ff <= BIT_LAST;
            cap_ff <= 8'h00;
        end else if (cs_n_s) begin
            oe_ff <= 1'b0;
            oidx_ff <= BIT_LAST;
        end else if (sck_fall & in_read) begin
            oe_ff <= 1'b1;
            oidx_ff <= oidx_ff - 3'h1;
            if (state_ff == SLRS_PREAD) begin
                so_ff <= sect_byte[oidx_ff];
            end else if (oidx_ff == BIT_LAST) begin
                so_ff <= device_status_word[ST_LOCK_BIT];
                cap_ff <= device_status_word;
            end else begin
                so_ff <= cap_ff[oidx_ff];
            end
        end
    end

    assign so_out = so_ff;
    assign so_oe = oe_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_sum_all: assert property (@(posedge clk_sys) disable iff (rst)
        (&prot_ff) |-> (device_status_word[ST_SUM_HI:ST_SUM_LO] == SUM_ALL))
        else $error("summary not all for all sectors set");
    chk_sum_mix: assert property (@(posedge clk_sys) disable iff (rst)
        ((|prot_ff) && !(&prot_ff)) |-> (summary == SUM_SOME))
        else $error("summary wrong for mixed sectors");
    chk_hw_freeze: assert property (@(posedge clk_sys) disable iff (rst)
        hw_lock |=> (prot_ff == $past(prot_ff)) && lock_ff)
        else $error("state changed under hardware lock");
    chk_sw_reject: assert property (@(posedge clk_sys) disable iff (rst)
        (lock_ff && sect_cmd_valid) |=> prot_ff == $past(prot_ff))
        else $error("sector command accepted while locked");
    chk_no_glb_clear: assert property (@(posedge clk_sys) disable iff (rst)
        ($past(lock_ff) && !lock_ff) |-> prot_ff == $past(prot_ff))
        else $error("global change while clearing lock");
    chk_pin_mirror: assert property (@(posedge clk_sys) disable iff (rst)
        (!$past(rst) && !$past(rst, 2)) |-> device_status_word[ST_PIN_BIT] == $past(wp_n, 2))
        else $error("pin status bit mismatch");
    chk_so_release: assert property (@(posedge clk_sys) disable iff (rst)
        cs_n_s |=> !so_oe ##1 !so_oe)
        else $error("output driven after release");
    chk_wel_drop: assert property (@(posedge clk_sys) disable iff (rst)
        (cs_end && wcmd_ff) |=> wel_clear ##1 !wel_clear)
        else $error("latch clear pulse missing");
    chk_sect_data: assert property (@(posedge clk_sys) disable iff (rst)
        (sck_fall && state_ff == SLRS_PREAD) |=> so_out == $past(prot_ff[sel_sect]))
        else $error("sector readout bit wrong");
endmodule : slrs_top
